// ==== core/vip_top.v ====
// Vectored interrupt prioritizer: arbitration, request to the core and vector fetch.
// Assumes all inputs are synchronous to mclk and program memory answers one cycle after a fetch strobe.
`timescale 1ns/10ps
`default_nettype none
`include "vip_defs.vh"

module vip_top #(
    parameter NTRAP = `VIP_NTRAP,
    parameter NIRQ = `VIP_NIRQ,
    parameter PRIO_W = `VIP_PRIO_W,
    parameter VEC_W = `VIP_VEC_W,
    parameter ADDR_W = `VIP_ADDR_W
) (
    input wire mclk,
    input wire rst,
    input wire [NTRAP-1:0] trap_req,
    input wire [NIRQ-1:0] irq_flag,
    input wire [NIRQ-1:0] irq_enable,
    input wire [NIRQ*PRIO_W-1:0] irq_level,
    input wire [PRIO_W-1:0] core_level,
    input wire core_ack,
    input wire core_ret,
    output wire core_req,
    output wire core_req_trap,
    output wire [VEC_W-1:0] core_req_vec,
    output wire [PRIO_W-1:0] core_req_level,
    output wire fetch_en,
    output wire [ADDR_W-1:0] fetch_addr,
    input wire [ADDR_W-1:0] fetch_data,
    output wire isr_valid,
    output wire [ADDR_W-1:0] isr_addr,
    output wire [VEC_W-1:0] isr_vec,
    output wire ret_done,
    output wire busy
);

    // ****************************************
    // Helpers
    // ****************************************

    function [ADDR_W-1:0] vec_addr;
        input [VEC_W-1:0] vec;
        reg [ADDR_W-1:0] wide;
        begin
            wide = {{(ADDR_W-VEC_W){1'b0}}, vec};
            vec_addr = `VIP_TABLE_BASE + wide * `VIP_TABLE_STRIDE;
        end
    endfunction

    function [PRIO_W-1:0] level_of;
        input [NIRQ*PRIO_W-1:0] levels;
        input integer idx;
        begin
            level_of = levels[idx*PRIO_W +: PRIO_W];
        end
    endfunction

    // Sequencer decodes, shared by next state and outputs
    function at_idle;
        input [1:0] st;
        begin
            at_idle = (st == `VIP_ST_IDLE);
        end
    endfunction

    function entry_last;
        input [1:0] st;
        input [3:0] cnt;
        begin
            entry_last = (st == `VIP_ST_WAIT) && (cnt == `VIP_ENTRY_CYC - 4'h1);
        end
    endfunction

    function ret_last;
        input [1:0] st;
        input [3:0] cnt;
        begin
            ret_last = (st == `VIP_ST_RET) && (cnt == `VIP_RET_CYC - 4'h1);
        end
    endfunction

    function [3:0] cnt_step;
        input [3:0] cnt;
        begin
            cnt_step = cnt + 4'h1;
        end
    endfunction

    // ****************************************
    // Combinational arbitration
    // ****************************************
    reg trap_any;
    reg [VEC_W-1:0] trap_vec;
    reg irq_any;
    reg [VEC_W-1:0] irq_vec;
    reg [PRIO_W-1:0] irq_best;
    reg [PRIO_W-1:0] lvl;
    integer i;
    integer j;
    // Flags are kept outside; nothing here clears them
    localparam [VEC_W-1:0] IRQ_BASE = NTRAP[VEC_W-1:0];

    always @* begin
        trap_any = 1'b0;
        trap_vec = {VEC_W{1'b0}};
        // High to low, so the lowest pending trap writes last
        for (i = NTRAP - 1; i >= 0; i = i - 1) begin
            if (trap_req[i]) begin
                trap_any = 1'b1;
                trap_vec = i[VEC_W-1:0];
            end
        end
    end

    always @* begin
        irq_any = 1'b0;
        irq_vec = {VEC_W{1'b0}};
        irq_best = {PRIO_W{1'b0}};
        lvl = {PRIO_W{1'b0}};
        for (j = 0; j < NIRQ; j = j + 1) begin
            lvl = level_of(irq_level, j);
            if (irq_flag[j] && irq_enable[j] && (!irq_any || lvl > irq_best)) begin
                irq_any = 1'b1;
                irq_best = lvl;
                irq_vec = j[VEC_W-1:0] + IRQ_BASE;
            end
        end
    end

    wire irq_allowed = irq_any && (irq_best > core_level);
    wire win_any = trap_any || irq_allowed;
    wire [VEC_W-1:0] win_vec = trap_any ? trap_vec : irq_vec;
    // Traps report the top level so the core can rank them
    wire [PRIO_W-1:0] win_level = trap_any ? {PRIO_W{1'b1}} : irq_best;

    // ****************************************
    // Registered request to the core
    // ****************************************
    reg req_q;
    reg req_trap_q;
    reg [VEC_W-1:0] req_vec_q;
    reg [PRIO_W-1:0] req_level_q;
    reg [1:0] state_q;
    wire idle = at_idle(state_q);

    // Single merged request
    // Request is withdrawn while a dispatch runs so the core never sees a stale vector
    // An ack or a return drops it on the next edge
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_q <= 1'b0;
            req_trap_q <= 1'b0;
            req_vec_q <= {VEC_W{1'b0}};
            req_level_q <= {PRIO_W{1'b0}};
        end else begin
            req_q <= win_any && idle && !core_ack && !core_ret;
            req_trap_q <= trap_any;
            req_vec_q <= win_vec;
            req_level_q <= win_level;
        end
    end

    assign core_req = req_q;
    assign core_req_trap = req_q & req_trap_q;
    assign core_req_vec = req_vec_q;
    assign core_req_level = req_level_q;

    // ****************************************
    // Entry and return sequencer
    // ****************************************
    reg [3:0] cnt_q;
    reg [3:0] cnt_d;
    reg [1:0] state_d;
    reg [VEC_W-1:0] svc_vec_q;
    reg [ADDR_W-1:0] isr_addr_q;
    reg isr_valid_q;
    reg ret_done_q;
    reg fetch_en_q;
    reg [ADDR_W-1:0] fetch_addr_q;

    wire take = idle && req_q && core_ack;
    wire give_back = idle && !take && core_ret;

    wire entry_end = entry_last(state_q, cnt_q);
    wire ret_end = ret_last(state_q, cnt_q);
    // Program memory answers one cycle after the strobe
    wire capture = (state_q == `VIP_ST_WAIT) && (cnt_q == `VIP_CAPT_CYC);

    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            `VIP_ST_IDLE: begin
                if (take) begin
                    state_d = `VIP_ST_FETCH;
                    cnt_d = 4'h1;
                end else if (give_back) begin
                    state_d = `VIP_ST_RET;
                    cnt_d = 4'h1;
                end
            end
            `VIP_ST_FETCH: begin
                state_d = `VIP_ST_WAIT;
                cnt_d = cnt_step(cnt_q);
            end
            `VIP_ST_WAIT: begin
                cnt_d = cnt_step(cnt_q);
                if (entry_end) begin
                    state_d = `VIP_ST_IDLE;
                    cnt_d = 4'h0;
                end
            end
            `VIP_ST_RET: begin
                cnt_d = cnt_step(cnt_q);
                if (ret_end) begin
                    state_d = `VIP_ST_IDLE;
                    cnt_d = 4'h0;
                end
            end
            default: begin
                state_d = `VIP_ST_IDLE;
                cnt_d = 4'h0;
            end
        endcase
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= `VIP_ST_IDLE;
            cnt_q <= 4'h0;
            svc_vec_q <= {VEC_W{1'b0}};
            isr_addr_q <= `VIP_RESET_ADDR;
            isr_valid_q <= 1'b0;
            ret_done_q <= 1'b0;
            fetch_en_q <= 1'b0;
            fetch_addr_q <= {ADDR_W{1'b0}};
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (take) begin
                svc_vec_q <= req_vec_q;
            end
            fetch_en_q <= take;
            if (take) begin
                fetch_addr_q <= vec_addr(req_vec_q);
            end
            if (capture) begin
                isr_addr_q <= fetch_data;
            end
            isr_valid_q <= entry_end;
            ret_done_q <= ret_end;
        end
    end

    // ****************************************
    // Output drive
    // ****************************************

    assign fetch_en = fetch_en_q;
    assign fetch_addr = fetch_addr_q;
    assign isr_valid = isr_valid_q;
    assign isr_addr = isr_addr_q;
    assign isr_vec = svc_vec_q;
    assign ret_done = ret_done_q;
    // Decoded, not registered, so it falls with the state
    assign busy = !idle;

endmodule

`default_nettype wire

// ==== core/vip_defs.vh ====
// Constants for the vectored interrupt prioritizer.
// Assumes program memory is word addressed in steps of two, as the core sees it.
`ifndef VIP_DEFS_VH
`define VIP_DEFS_VH

// ****************************************
// Source counts and widths
// ****************************************
`define VIP_NTRAP 7
`define VIP_NIRQ 151
`define VIP_PRIO_W 3
`define VIP_VEC_W 8
`define VIP_ADDR_W 24

// ****************************************
// Vector table placement
// ****************************************
`define VIP_TABLE_BASE 24'h000004
`define VIP_TABLE_STRIDE 24'h000002
`define VIP_RESET_ADDR 24'h000000

// ****************************************
// Fixed latencies in mclk cycles
// ****************************************
`define VIP_ENTRY_CYC 4'h4
`define VIP_RET_CYC 4'h3
`define VIP_CAPT_CYC 4'h2

// ****************************************
// Sequencer states
// ****************************************
`define VIP_ST_IDLE 2'h0
`define VIP_ST_FETCH 2'h1
`define VIP_ST_WAIT 2'h2
`define VIP_ST_RET 2'h3

`endif

// ==== dv/vip_checker.sv ====
// Port checker for the interrupt prioritizer.
// Assumes a bind onto vip_top and one clock.
`timescale 1ns/10ps
`default_nettype none
module vip_checker #(
    parameter NTRAP = 7
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [NTRAP-1:0] trap_req,
    input wire logic core_ack,
    input wire logic core_ret,
    input wire logic core_req,
    input wire logic core_req_trap,
    input wire logic [7:0] core_req_vec,
    input wire logic [2:0] core_req_level,
    input wire logic fetch_en,
    input wire logic [23:0] fetch_addr,
    input wire logic [23:0] fetch_data,
    input wire logic isr_valid,
    input wire logic [23:0] isr_addr,
    input wire logic [7:0] isr_vec,
    input wire logic ret_done,
    input wire logic busy
);
    // ****
    // Properties
    // ****
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire take = core_ack && core_req && !busy;
    property p_entry; take |=> busy && fetch_en && !core_req && isr_vec == $past(core_req_vec); endproperty
    a_entry: assert property (p_entry) else $error("entry start wrong");
    property p_addr; fetch_en |-> fetch_addr == 24'h000004 + {15'h0, isr_vec, 1'b0}; endproperty
    a_addr: assert property (p_addr) else $error("fetch address wrong");
    property p_lat; take |-> ##4 isr_valid ##1 !isr_valid && !busy; endproperty
    a_lat: assert property (p_lat) else $error("entry latency wrong");
    property p_word; fetch_en |-> ##2 isr_addr == $past(fetch_data); endproperty
    a_word: assert property (p_word) else $error("handler word wrong");
    property p_ret; core_ret && !busy && !take |-> ##3 ret_done ##1 !busy; endproperty
    a_ret: assert property (p_ret) else $error("return latency wrong");
    property p_trap; core_req_trap |-> core_req && core_req_level == 3'h7; endproperty
    a_trap: assert property (p_trap) else $error("trap level wrong");
    property p_first; trap_req[0] && !busy && !core_ack && !core_ret |=> core_req_trap && core_req_vec == 8'h00; endproperty
    a_first: assert property (p_first) else $error("vector zero lost");
    property p_quiet; busy |-> !core_req; endproperty
    a_quiet: assert property (p_quiet) else $error("request during busy");
    property p_unmask; |trap_req && !busy && !core_ack && !core_ret |=> core_req && core_req_trap; endproperty
    a_unmask: assert property (p_unmask) else $error("trap request lost");
endmodule
`default_nettype wire

// ==== dv/vip_prog_mem.sv ====
// Program memory model holding the vector table.
// Assumes one fetch strobe per word, answer next cycle.
`timescale 1ns/10ps
`default_nettype none
module vip_prog_mem (
    input wire logic mclk,
    input wire logic fetch_en,
    input wire logic [23:0] fetch_addr,
    output logic [23:0] fetch_data
);
    // ****
    // Table read
    // ****
    initial fetch_data = 24'h000000;
    always @(posedge mclk) begin
        if (fetch_en) begin
            fetch_data <= fetch_addr ^ 24'hA50000;
        end else begin
            // Toggle so a late capture cannot pass
            fetch_data <= ~fetch_data;
        end
    end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the interrupt prioritizer.
// Assumes the checker and memory model files compile first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    // ****
    // Bench
    // ****
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] trap_req = 7'h00;
    logic [150:0] irq_flag = 151'h0;
    logic [150:0] irq_enable = 151'h0;
    logic [452:0] irq_level = 453'h0;
    logic [2:0] core_level = 3'h0;
    logic core_ack = 1'b0;
    logic core_ret = 1'b0;
    wire core_req, core_req_trap, fetch_en, isr_valid, ret_done, busy;
    wire [7:0] core_req_vec, isr_vec;
    wire [2:0] core_req_level;
    wire [23:0] fetch_addr, fetch_data, isr_addr;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    vip_top vip_top_inst (.mclk(mclk), .rst(rst), .trap_req(trap_req), .irq_flag(irq_flag),
        .irq_enable(irq_enable), .irq_level(irq_level), .core_level(core_level), .core_ack(core_ack),
        .core_ret(core_ret), .core_req(core_req), .core_req_trap(core_req_trap), .core_req_vec(core_req_vec),
        .core_req_level(core_req_level), .fetch_en(fetch_en), .fetch_addr(fetch_addr), .fetch_data(fetch_data),
        .isr_valid(isr_valid), .isr_addr(isr_addr), .isr_vec(isr_vec), .ret_done(ret_done), .busy(busy));
    vip_prog_mem vip_prog_mem_inst (.mclk(mclk), .fetch_en(fetch_en), .fetch_addr(fetch_addr),
        .fetch_data(fetch_data));
    initial forever #5 mclk = ~mclk;
    task tick; @(posedge mclk); #1; endtask
    task set_irq(input int i, input logic [2:0] l);
        irq_flag[i] = 1'b1;
        irq_enable[i] = 1'b1;
        irq_level[3*i +: 3] = l;
    endtask
    task req(input logic [11:0] e);
        tick;
        `CHK({core_req, core_req_vec, core_req_level}, e)
    endtask
    task t_arb;
        core_level = 3'h2;
        set_irq(3, 3'h5);
        req({1'b1, 8'h0A, 3'h5});
        set_irq(1, 3'h5);
        req({1'b1, 8'h08, 3'h5});
        set_irq(150, 3'h6);
        req({1'b1, 8'h9D, 3'h6});
        core_level = 3'h6;
        tick;
        `CHK(core_req, 1'b0)
        irq_enable[1] = 1'b0;
        irq_enable[150] = 1'b0;
        core_level = 3'h4;
        req({1'b1, 8'h0A, 3'h5});
    endtask
    task t_trap;
        core_level = 3'h7;
        for (int i = 0; i < 7; i++) begin
            trap_req = 7'h7F << i;
            tick;
            `CHK({core_req_trap, core_req_vec, core_req_level}, {1'b1, i[7:0], 3'h7})
        end
    endtask
    task t_entry(input logic [7:0] v);
        core_ack = 1'b1;
        tick;
        core_ack = 1'b0;
        `CHK({busy, fetch_en, fetch_addr}, {2'h3, 24'h000004 + {15'h0, v, 1'b0}})
        tick;
        tick;
        `CHK(isr_valid, 1'b0)
        tick;
        `CHK({isr_valid, isr_vec, isr_addr}, {1'b1, v, (24'h000004 + {15'h0, v, 1'b0}) ^ 24'hA50000})
        tick;
        `CHK(busy, 1'b0)
    endtask
    task t_ret;
        // Held two cycles: the second is refused
        core_ret = 1'b1;
        tick;
        `CHK(busy, 1'b1)
        tick;
        core_ret = 1'b0;
        tick;
        `CHK(ret_done, 1'b1)
        tick;
        `CHK({ret_done, busy}, 2'h0)
    endtask
    task t_both;
        // Ack and return together: the ack wins
        core_ack = 1'b1;
        core_ret = 1'b1;
        tick;
        core_ack = 1'b0;
        core_ret = 1'b0;
        `CHK({busy, fetch_en}, 2'h3)
        repeat (4) tick;
        `CHK({busy, ret_done, isr_vec}, {2'h0, 8'h9D})
    endtask
    task t_refuse;
        // Equal level is refused, and so is an ack with no request
        core_level = 3'h7;
        tick;
        core_ack = 1'b1;
        tick;
        core_ack = 1'b0;
        `CHK({core_req, busy, fetch_en}, 3'h0)
    endtask
    task print_verdict;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            print_verdict;
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        #1 rst = 1'b0;
        `CHK({isr_addr, isr_valid, busy}, 26'h0)
        t_arb;
        t_trap;
        trap_req = 7'h01;
        tick;
        t_entry(8'h00);
        trap_req = 7'h00;
        irq_enable = 151'h0;
        set_irq(150, 3'h7);
        core_level = 3'h0;
        tick;
        t_entry(8'h9D);
        t_ret;
        t_both;
        t_refuse;
        print_verdict;
    end
endmodule
bind vip_top vip_checker #(.NTRAP(NTRAP)) vip_checker_inst (.mclk(mclk), .rst(rst), .trap_req(trap_req),
    .core_ack(core_ack), .core_ret(core_ret), .core_req(core_req), .core_req_trap(core_req_trap),
    .core_req_vec(core_req_vec), .core_req_level(core_req_level), .fetch_en(fetch_en), .fetch_addr(fetch_addr),
    .fetch_data(fetch_data), .isr_valid(isr_valid), .isr_addr(isr_addr), .isr_vec(isr_vec),
    .ret_done(ret_done), .busy(busy));
`default_nettype wire
